// [hdl/gpio_pin_control_regs.vh]
/*
 Register offsets, field positions, reset values and encodings for the general purpose I/O port.
 Assumes an AXI4-Lite master with 32-bit data and byte addressing; each register takes one aligned word.
*/
`ifndef GPIO_PIN_CONTROL_REGS_VH
`define GPIO_PIN_CONTROL_REGS_VH

`define GPIO_WIDTH             8
`define GPIO_ADDR_W            8

`define REG_INPUT_SAMPLE       8'h00
`define REG_DIRECTION          8'h04
`define REG_OUTPUT_LATCH       8'h08
`define REG_CONTROL            8'h0c
`define REG_EXTINT_SELECT      8'h10
`define REG_EXTINT_SENSE       8'h14
`define REG_IRQ_STATUS         8'h18
`define REG_IRQ_CLEAR          8'h1c
`define REG_IRQ_ENABLE         8'h20

`define CTRL_PULLUP_DISABLE    4

`define RST_DIRECTION          8'h00
`define RST_OUTPUT_LATCH       8'h00
`define RST_PULLUP_DISABLE     1'b0
`define RST_EXTINT_SELECT      8'h00
`define RST_EXTINT_SENSE       16'h0000
`define RST_IRQ_STATUS         8'h00
`define RST_IRQ_ENABLE         8'h00

`define SENSE_LOW_LEVEL        2'h0
`define SENSE_ANY_CHANGE       2'h1
`define SENSE_FALLING          2'h2
`define SENSE_RISING           2'h3

`define SLEEP_ACTIVE           3'h0
`define SLEEP_IDLE             3'h1
`define SLEEP_ADC_NOISE        3'h2
`define SLEEP_POWER_DOWN       3'h3
`define SLEEP_POWER_SAVE       3'h4
`define SLEEP_STANDBY          3'h6

`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`define SYNC_DELAY_CYCLES      1

`endif

// [hdl/gpio_input_sync.v]
/*
 Two-stage input synchroniser for the port pins: a stage that holds the level seen at the falling
 clock edge, followed by the sample register loaded on the rising edge.
 Assumes a single clock whose low phase stands in for the closed phase of a transparent-high latch.
*/
module gpio_input_sync (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Pin levels after the sleep clamp
	input  wire [7:0] pad_level,
	// Synchronised samples
	output reg  [7:0] sample
);

	reg [7:0] half_stage;

	// The level is frozen when the clock falls, as a transparent-high latch would hold it.
	always @(negedge aclk) begin
		half_stage <= pad_level;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			sample <= 8'h00;
		end else begin
			sample <= half_stage;
		end
	end

endmodule

// [hdl/gpio_pin_control.v]
/*
 One eight-pin general purpose I/O port with direction, output latch, synchronised input samples,
 global pull-up disable, sleep clamping of the digital inputs and external interrupt flags.
 Assumes an AXI4-Lite master on aclk, pins sampled as synchronous inputs and a sleep controller
 that presents the current sleep mode on sleep_mode.
*/
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`include "gpio_pin_control_regs.vh"

module gpio_pin_control (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  awaddr,
	input  wire [2:0]  awprot,
	input  wire        awvalid,
	output reg         awready,
	// AXI4-Lite write data
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	// AXI4-Lite write response
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	// AXI4-Lite read address
	input  wire [7:0]  araddr,
	input  wire [2:0]  arprot,
	input  wire        arvalid,
	output reg         arready,
	// AXI4-Lite read data
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	// Pins
	input  wire [7:0]  pad_in,
	output wire [7:0]  pad_out,
	output wire [7:0]  pad_oe_n,
	output wire [7:0]  pad_pullup_en,
	// Sleep controller and alternate functions
	input  wire [2:0]  sleep_mode,
	input  wire [7:0]  input_enable_override,
	// Interrupt
	output reg         irq
);

	reg  [7:0]  port_direction_register;
	reg  [7:0]  port_output_latch;
	reg         global_pullup_disable;
	reg  [7:0]  extint_select;
	reg  [15:0] extint_sense;
	reg  [7:0]  irq_status;
	reg  [7:0]  irq_enable;

	reg         aw_held;
	reg  [7:0]  aw_addr_q;
	reg         w_held;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;

	reg  [7:0]  prev_sample;
	reg  [7:0]  edge_event;
	reg  [7:0]  low_level_req;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;
	reg  [1:0]  next_bresp;
	reg  [7:0]  clear_mask;
	integer     i;

	wire [7:0]  pin_input_sample_bit;
	wire [7:0]  sample_rise;
	wire [7:0]  sample_fall;
	wire [7:0]  clamp_mask;
	wire [7:0]  pad_level;
	wire        do_write;

	function [7:0] merge8;
		input [7:0] old_value;
		input [7:0] new_value;
		input       lane_enable;
		begin
			merge8 = lane_enable ? new_value : old_value;
		end
	endfunction

	function is_clamp_mode;
		input [2:0] mode;
		begin
			is_clamp_mode = (mode == `SLEEP_POWER_DOWN) || (mode == `SLEEP_POWER_SAVE) ||
			                (mode == `SLEEP_STANDBY);
		end
	endfunction

	function edge_hit;
		input [1:0] sense;
		input       rise;
		input       fall;
		begin
			case (sense)
				`SENSE_ANY_CHANGE: edge_hit = rise | fall;
				`SENSE_FALLING:    edge_hit = fall;
				`SENSE_RISING:     edge_hit = rise;
				default:           edge_hit = 1'b0;
			endcase
		end
	endfunction

	// Sticky flag update. A clear removes only what no new event sets in the same cycle.
	function [7:0] next_flags;
		input [7:0] flags;
		input [7:0] clear;
		input [7:0] events;
		begin
			next_flags = (flags & ~clear) | events;
		end
	endfunction

	// Pin drivers. Reset gates the enables without waiting for a clock edge, so the pins float
	// the moment reset asserts even if the clock has stopped.
	assign pad_out       = port_output_latch;
	assign pad_oe_n      = ~(port_direction_register & {8{aresetn}});
	assign pad_pullup_en = {8{aresetn}} & ~port_direction_register & port_output_latch &
	                       {8{~global_pullup_disable}};

	// Deep sleep grounds the digital input ahead of the synchroniser, except on pins that serve as
	// enabled external interrupts or whose alternate function keeps the input alive.
	assign clamp_mask = {8{is_clamp_mode(sleep_mode)}} & ~(extint_select & irq_enable) &
	                    ~input_enable_override;
	assign pad_level  = pad_in & ~clamp_mask;

	gpio_input_sync u_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pad_level (pad_level),
		.sample    (pin_input_sample_bit)
	);

	// External interrupt detection runs on the synchronised samples. When a clamped pin is released
	// at wake-up and is high, the sample rises and a pin sensing rising edges or any change flags it.
	// Edges are taken between two synchronised samples, so a glitch shorter than a period is missed unless it spans a falling clock edge.
	assign sample_rise = pin_input_sample_bit & ~prev_sample;
	assign sample_fall = ~pin_input_sample_bit & prev_sample;

	always @* begin
		edge_event    = 8'h00;
		low_level_req = 8'h00;
		for (i = 0; i < `GPIO_WIDTH; i = i + 1) begin
			edge_event[i]    = extint_select[i] & edge_hit(extint_sense[2*i +: 2], sample_rise[i],
			                                               sample_fall[i]);
			low_level_req[i] = extint_select[i] & ~pin_input_sample_bit[i] &
			                   (extint_sense[2*i +: 2] == `SENSE_LOW_LEVEL);
		end
	end

	// Reset clears the edge history to the low level of a clamped input. A pin already high after
	// reset then shows one rising edge, but the select register is clear by then, so no flag follows.
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_sample <= 8'h00;
		end else begin
			prev_sample <= pin_input_sample_bit;
		end
	end

	// Write channel: address and data are taken independently and held until both are present.
	// Unmapped offsets are answered with an error and change nothing.
	assign do_write = aw_held && w_held && !bvalid;

	always @* begin
		clear_mask = 8'h00;
		next_bresp = `RESP_OKAY;
		case (aw_addr_q)
			`REG_INPUT_SAMPLE,
			`REG_DIRECTION,
			`REG_OUTPUT_LATCH,
			`REG_CONTROL,
			`REG_EXTINT_SELECT,
			`REG_EXTINT_SENSE,
			`REG_IRQ_STATUS,
			`REG_IRQ_ENABLE: next_bresp = `RESP_OKAY;
			`REG_IRQ_CLEAR: begin
				next_bresp = `RESP_OKAY;
				if (do_write && w_strb_q[0]) begin
					clear_mask = w_data_q[7:0];
				end
			end
			default: next_bresp = `RESP_SLVERR;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= `RESP_OKAY;
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
				awready   <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				wready   <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= next_bresp;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Register file. Reserved bits are not stored and read as zero.
	// A one written to the input sample location flips the latch and leaves direction alone, so
	// software can flip a pin without a read-modify-write of the latch.
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_direction_register <= `RST_DIRECTION;
			port_output_latch       <= `RST_OUTPUT_LATCH;
			global_pullup_disable   <= `RST_PULLUP_DISABLE;
			extint_select           <= `RST_EXTINT_SELECT;
			extint_sense            <= `RST_EXTINT_SENSE;
			irq_enable              <= `RST_IRQ_ENABLE;
		end else if (do_write) begin
			case (aw_addr_q)
				`REG_INPUT_SAMPLE: begin
					if (w_strb_q[0]) begin
						port_output_latch <= port_output_latch ^ w_data_q[7:0];
					end
				end
				`REG_DIRECTION: begin
					port_direction_register <= merge8(port_direction_register, w_data_q[7:0], w_strb_q[0]);
				end
				`REG_OUTPUT_LATCH: begin
					port_output_latch <= merge8(port_output_latch, w_data_q[7:0], w_strb_q[0]);
				end
				`REG_CONTROL: begin
					if (w_strb_q[0]) begin
						global_pullup_disable <= w_data_q[`CTRL_PULLUP_DISABLE];
					end
				end
				`REG_EXTINT_SELECT: begin
					extint_select <= merge8(extint_select, w_data_q[7:0], w_strb_q[0]);
				end
				`REG_EXTINT_SENSE: begin
					extint_sense[7:0]  <= merge8(extint_sense[7:0], w_data_q[7:0], w_strb_q[0]);
					extint_sense[15:8] <= merge8(extint_sense[15:8], w_data_q[15:8], w_strb_q[1]);
				end
				`REG_IRQ_ENABLE: begin
					irq_enable <= merge8(irq_enable, w_data_q[7:0], w_strb_q[0]);
				end
				default: begin
					irq_enable <= irq_enable;
				end
			endcase
		end
	end

	// A new event in the same cycle as its clear keeps the flag set.
	// A low-level pin sets no flag; it holds the interrupt line up only while it stays low, which
	// keeps the request alive without software having to clear anything.
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= `RST_IRQ_STATUS;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_flags(irq_status, clear_mask, edge_event);
			irq        <= |((next_flags(irq_status, clear_mask, edge_event) | low_level_req) & irq_enable);
		end
	end

	// Read channel: one read at a time, answered the cycle after the address is taken.
	// A pin just set by software reaches the sample one period after the write lands, so a read
	// taken at the very next edge still returns the old level.
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `RESP_OKAY;
		case (araddr)
			`REG_INPUT_SAMPLE:  next_rdata[7:0] = pin_input_sample_bit;
			`REG_DIRECTION:     next_rdata[7:0] = port_direction_register;
			`REG_OUTPUT_LATCH:  next_rdata[7:0] = port_output_latch;
			`REG_CONTROL:       next_rdata[`CTRL_PULLUP_DISABLE] = global_pullup_disable;
			`REG_EXTINT_SELECT: next_rdata[7:0] = extint_select;
			`REG_EXTINT_SENSE:  next_rdata[15:0] = extint_sense;
			`REG_IRQ_STATUS:    next_rdata[7:0] = irq_status;
			`REG_IRQ_CLEAR:     next_rdata = 32'h00000000;
			`REG_IRQ_ENABLE:    next_rdata[7:0] = irq_enable;
			default:            next_rresp = `RESP_SLVERR;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= next_rdata;
				rresp   <= next_rresp;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

// [bench/gpio_pin_control_sva.sv]
/* Assertions on the port's pins and register bus.
 Assumes binding to the port top, one clock, one write or read at a time. */
module gpio_pin_control_sva (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	// Pins
	input wire logic [7:0]  pad_out,
	input wire logic [7:0]  pad_oe_n,
	input wire logic [7:0]  pad_pullup_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire       wt = awvalid && awready && wvalid && wready;
	wire [7:0] wlo = wdata[7:0];
	// Reset is the cause here, so it cannot also switch the check off.
	a_reset_tristate: assert property (disable iff (1'b0)
		!aresetn |-> pad_oe_n == 8'hff && pad_pullup_en == 8'h00) else $error("pins active in reset");
	a_output_nopull: assert property ((pad_pullup_en & ~pad_oe_n) == 8'h00)
		else $error("pull-up on driven pin");
	a_pull_latch: assert property ((pad_pullup_en & ~pad_out) == 8'h00)
		else $error("pull-up with latch low");
	a_toggle_latch: assert property (wt && awaddr == 8'h00 |->
		##2 pad_out == ($past(pad_out, 2) ^ $past(wlo, 2))) else $error("toggle wrong");
	a_latch_write: assert property (wt && awaddr == 8'h08 |-> ##2 pad_out == $past(wlo, 2))
		else $error("latch write lost");
	a_dir_write: assert property (wt && awaddr == 8'h04 |-> ##2 pad_oe_n == ~$past(wlo, 2))
		else $error("direction write lost");
	a_write_answer: assert property (wt |=> !bvalid ##1 bvalid)
		else $error("write answer late");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_reset_clear: assert property ($rose(aresetn) |-> pad_out == 8'h00 && pad_oe_n == 8'hff)
		else $error("reset state wrong");
	cover property (wt && awaddr == 8'h00);
	cover property (rvalid && !rready);
	cover property (pad_pullup_en != 8'h00);
endmodule

bind gpio_pin_control gpio_pin_control_sva chk (
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
	.wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .pad_out(pad_out),
	.pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en)
);

// [bench/gpio_pad_model.sv]
/* Board around the eight pins: an optional outside driver per pin, else pull-up or a floating level.
 Assumes the bench sets drive_en and drive_val; a pin driven by the port wins. */
module gpio_pad_model (
	// Port side
	input wire logic       aclk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_n,
	input wire logic [7:0] pad_pullup_en,
	// Board side
	input wire logic [7:0] drive_en,
	input wire logic [7:0] drive_val,
	output logic     [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] flo = 8'h00;
	// A floating pin flips every cycle so that a stale level never looks valid.
	always @(posedge aclk)
		flo <= ~flo;
	assign pad_in = ~pad_oe_n & pad_out | pad_oe_n & (drive_en & drive_val | ~drive_en & (pad_pullup_en | flo));
endmodule

// [bench/gpio_pin_control_test.sv]
/* Self-checking test of the I/O port: bus tasks, random pin setups, sleep clamp, flags, reset.
 Assumes the design, the pad model and the checker are compiled first. */
`include "gpio_pin_control_regs.vh"
module gpio_pin_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0, ext_en = 0, ext_val = 0, ovr = 0, dir, lat, pull, m;
	logic [31:0] wdata = 0, rs = 32'd74599, d, t;
	logic [2:0]  sleep = 0;
	wire         awready, wready, bvalid, arready, rvalid, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  pad_in, pad_out, oe_n, pu;
	int          failures = 0, checked = 0, cycles = 0;
	gpio_pin_control DUT (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(oe_n),
		.pad_pullup_en(pu), .sleep_mode(sleep), .input_enable_override(ovr), .irq(irq));
	gpio_pad_model board (.aclk(aclk), .pad_out(pad_out), .pad_oe_n(oe_n), .pad_pullup_en(pu),
		.drive_en(ext_en), .drive_val(ext_val), .pad_in(pad_in));
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			test_done();
		end
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input [31:0] g, input [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] v, input [1:0] er = 0);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
		end while (awvalid || wvalid);
		do @(posedge aclk); while (!bvalid);
		chk(bresp, er);
		bready <= 0;
	endtask
	// Ready is raised a cycle late on purpose, so that held read data is exercised.
	task automatic rd(input [7:0] a, output [31:0] v, input [1:0] er = 0);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		@(posedge aclk);
		rready <= 1;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		chk(rresp, er);
		rready <= 0;
	endtask
	task automatic test_done();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk(oe_n, 8'hff);
		for (int a = 4; a <= 12; a += 4) begin
			rd(a, d);
			chk(d, 0);
		end
		for (int i = 0; i < 12; i++) begin
			d = xs();
			t = xs();
			ext_en <= d[31:24];
			ext_val <= d[23:16];
			{lat, dir} = t[15:0];
			wr(`REG_CONTROL, 32'(d[0]) << `CTRL_PULLUP_DISABLE);
			// Latch before direction keeps every step through an allowed middle state.
			wr(`REG_OUTPUT_LATCH, {24'h0, lat});
			wr(`REG_DIRECTION, {24'h0, dir});
			pull = ~dir & lat & ~{8{d[0]}};
			chk(pu, pull);
			chk({oe_n, pad_out}, {~dir, lat});
			rd(`REG_INPUT_SAMPLE, d);
			m = dir | ext_en | pull;
			chk(d[7:0] & m, (dir & lat | ~dir & (ext_en & ext_val | ~ext_en)) & m);
			wr(`REG_INPUT_SAMPLE, {24'h0, t[23:16]});
			rd(`REG_OUTPUT_LATCH, d);
			chk(d, lat ^ t[23:16]);
		end
		$display("test random pins done");
		wr(8'h40, 1, 2);
		rd(8'h40, d, 2);
		chk(d, 0);
		wr(`REG_IRQ_STATUS, 32'hff);
		rd(`REG_IRQ_STATUS, d);
		chk(d, 0);
		wr(`REG_OUTPUT_LATCH, 0);
		wr(`REG_DIRECTION, 0);
		ext_en <= 8'hff;
		ext_val <= 8'hff;
		for (int s = 0; s < 7; s += (s == 4) ? 2 : 1) begin
			sleep <= s[2:0];
			repeat (3) @(posedge aclk);
			rd(`REG_INPUT_SAMPLE, d);
			chk(d, (s == 3 || s == 4 || s == 6) ? 0 : 32'hff);
		end
		wr(`REG_EXTINT_SELECT, 32'hff);
		wr(`REG_IRQ_ENABLE, 32'h0f);
		ovr <= 8'h30;
		rd(`REG_INPUT_SAMPLE, d);
		chk(d, 32'h3f);
		ovr <= 0;
		wr(`REG_IRQ_ENABLE, 0);
		$display("test clamp done");
		for (int s = 1; s < 4; s++) begin
			sleep <= 0;
			wr(`REG_EXTINT_SENSE, {16'h0, {8{s[1:0]}}});
			wr(`REG_IRQ_CLEAR, 32'hff);
			sleep <= 3'h3;
			repeat (4) @(posedge aclk);
			sleep <= 0;
			// A rising pin needs a sample edge and then a flag edge before the status shows it.
			repeat (3) @(posedge aclk);
			rd(`REG_IRQ_STATUS, d);
			chk(d, 32'hff);
			chk(irq, 0);
		end
		wr(`REG_IRQ_ENABLE, 1);
		@(posedge aclk);
		chk(irq, 1);
		wr(`REG_IRQ_CLEAR, 32'hff);
		chk(irq, 0);
		$display("test flags done");
		wr(`REG_CONTROL, 0);
		wr(`REG_OUTPUT_LATCH, 32'hff);
		wr(`REG_DIRECTION, 32'h0f);
		chk({pu, oe_n}, 16'hf0f0);
		@(posedge aclk);
		aresetn <= 0;
		#1;
		chk({pu, oe_n}, 16'h00ff);
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(`REG_OUTPUT_LATCH, d);
		chk(d, 0);
		$display("test reset done");
		test_done();
	end
endmodule
